/* dram_power_management.v */
/*
 * DRAM interface power management and pin control: per-rank power-down,
 * refresh wake, conditional self-refresh, pin tri-stating for unpopulated
 * ranks, CKE retention during power gating, training restore and
 * ascending/descending CA/CS order per x16 sub-channel.
 * Assumes a 10 MHz system clock and a slower DRAM clock arriving as a pin
 * that is sampled here to mark DRAM clock cycles.
 */
// Functional notes
// - Per sub-channel selectable descending CA/CS order.
// - Tri-state outputs toward absent memory.
// - Unpopulated rank: stop clock and chip-select.
// - Reset treats all ranks populated; software proves empty.
// - Modes: none, precharged, active power-down.
// - Precharged power-down only with all banks closed.
// - Honour exit delay; pages closed after precharged or self-refresh exit.
// - Close open pages before precharged power-down.
// - Per-rank idle counter gates power-down entry.
// - Threshold counts idle DRAM clock cycles.
// - Threshold writable unless registers locked.
// - Gate rank clock while powered down.
// - Wake all ranks for refresh, then return.
// - Self-refresh in C3 or deeper when idle.
// - Flush, then self-refresh non-graphics ranks, CKE low.
// - Unused signal: driver, receiver off; input gated.
// - Hold CKE during power gating.
// - Restore stored training on state return.
`timescale 1ns/1ps
`include "dram_pm_regs.vh"

module dram_power_management #(
	parameter RANKS   = 2,
	parameter SUBCH   = 2,
	parameter IDLE_W  = 16,
	parameter TXP_W   = 8,
	parameter TXP_NS  = `TXP_NS
)(
	input  wire                   clk_i,
	input  wire                   rst_i,
	input  wire                   dram_clk_i,
	input  wire [1:0]             power_down_config_i,
	input  wire [IDLE_W-1:0]      idle_thresh_wdata_i,
	input  wire                   idle_thresh_we_i,
	input  wire                   regs_locked_i,
	input  wire [RANKS-1:0]       rank_empty_i,
	input  wire [RANKS-1:0]       rank_busy_i,
	input  wire [RANKS-1:0]       rank_new_txn_i,
	input  wire [RANKS-1:0]       banks_precharged_i,
	input  wire [RANKS-1:0]       gfx_rank_i,
	input  wire                   refresh_req_i,
	input  wire [2:0]             pkg_cstate_i,
	input  wire                   s3_entry_i,
	input  wire                   pending_cycles_i,
	input  wire                   state_return_i,
	input  wire [SUBCH-1:0]       descending_i,
	input  wire [SUBCH*9-1:0]     ca_cs_logical_i,
	input  wire [SUBCH*9-1:0]     ca_cs_pad_in_i,
	input  wire [SUBCH-1:0]       subch_unused_i,
	output reg  [SUBCH*9-1:0]     ca_cs_pad_o,
	output reg  [SUBCH*9-1:0]     ca_cs_pad_oe_o,
	output reg  [SUBCH*9-1:0]     ca_cs_rx_o,
	output reg  [SUBCH-1:0]       rx_enable_o,
	output reg  [RANKS-1:0]       rank_clk_oe_o,
	output reg  [RANKS-1:0]       rank_cs_oe_o,
	output reg  [RANKS-1:0]       cke_o,
	output wire [RANKS-1:0]       rank_ready_o,
	output reg  [RANKS-1:0]       close_pages_o,
	output reg  [RANKS-1:0]       pages_closed_o,
	output reg  [RANKS-1:0]       in_self_refresh_o,
	output wire                   flush_req_o,
	output wire                   refresh_go_o,
	output reg                    interface_power_gating_o,
	output reg                    skip_training_o,
	output reg  [IDLE_W-1:0]      idle_thresh_o
);

	// Exit delay in system clocks, rounded up and at least one.
	localparam TXP_RAW = (TXP_NS * `CLK_MHZ + 999) / 1000;
	localparam TXP_CYC = (TXP_RAW < 1) ? 1 : TXP_RAW;
	localparam [TXP_W-1:0] TXP_CYCLES = TXP_CYC[TXP_W-1:0];

	reg  [2:0]       dram_clock_cycle_sync;
	reg  [RANKS-1:0] populated;
	reg  [SUBCH*9-1:0] pad_in_s1;
	reg  [SUBCH*9-1:0] pad_in_s2;
	reg              sref_req;
	reg              was_deep;
	wire [RANKS-1:0] cke_int;
	wire [RANKS-1:0] clk_en;
	wire [RANKS-1:0] close_int;
	wire [RANKS-1:0] pclosed_int;
	wire [RANKS-1:0] sref_int;
	wire             dram_clock_cycle_tick;
	wire             deep_state;
	wire             any_busy;

	assign dram_clock_cycle_tick  = dram_clock_cycle_sync[1] & ~dram_clock_cycle_sync[2];
	assign deep_state = (pkg_cstate_i >= `PKG_C3);
	assign any_busy   = |(rank_busy_i | rank_new_txn_i);
	// Flushing is asked for before any rank is allowed into self-refresh.
	assign flush_req_o = (s3_entry_i | deep_state) & pending_cycles_i;
	// Refresh waits until every populated rank is back out of power-down.
	assign refresh_go_o = refresh_req_i & (&(rank_ready_o | ~populated));

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			dram_clock_cycle_sync     <= 3'h0;
			pad_in_s1     <= {(SUBCH*9){1'b0}};
			pad_in_s2     <= {(SUBCH*9){1'b0}};
			populated     <= {RANKS{`POPULATED_RESET}};
			idle_thresh_o <= `IDLE_THRESH_RESET;
			sref_req      <= 1'b0;
			was_deep      <= 1'b0;
			skip_training_o          <= 1'b0;
			interface_power_gating_o <= 1'b0;
		end
		else
		begin
			dram_clock_cycle_sync <= {dram_clock_cycle_sync[1:0], dram_clk_i};
			pad_in_s1 <= ca_cs_pad_in_i;
			pad_in_s2 <= pad_in_s1;
			// Populated bits only ever clear; only a reset restores them.
			populated <= populated & ~rank_empty_i;
			if (idle_thresh_we_i && !regs_locked_i)
				idle_thresh_o <= idle_thresh_wdata_i;
			sref_req <= (deep_state || s3_entry_i) && !pending_cycles_i
				&& !any_busy;
			interface_power_gating_o <= deep_state;
			was_deep <= deep_state || s3_entry_i;
			// A return from a deep state restores stored training results.
			if (was_deep && !deep_state && !s3_entry_i)
				skip_training_o <= 1'b1;
			else if (state_return_i)
				skip_training_o <= 1'b1;
			else
				skip_training_o <= 1'b0;
		end
	end

	genvar r;
	generate
		for (r = 0; r < RANKS; r = r + 1)
		begin : g_rank
			rank_pm #(
				.IDLE_W (IDLE_W),
				.TXP_W  (TXP_W)
			) u_rank (
				.clk_i              (clk_i),
				.rst_i              (rst_i),
				.dram_clock_cycle_tick_i        (dram_clock_cycle_tick),
				.pd_mode_i          (power_down_config_i),
				.idle_thresh_i      (idle_thresh_o),
				.txp_cycles_i       (TXP_CYCLES),
				.busy_i             (rank_busy_i[r]),
				.new_txn_i          (rank_new_txn_i[r]),
				.banks_precharged_i (banks_precharged_i[r]),
				.refresh_req_i      (refresh_req_i),
				.sref_req_i         (sref_req),
				.gfx_rank_i         (gfx_rank_i[r]),
				.cke_o              (cke_int[r]),
				.clk_en_o           (clk_en[r]),
				.close_pages_o      (close_int[r]),
				.pages_closed_o     (pclosed_int[r]),
				.ready_o            (rank_ready_o[r]),
				.in_sref_o          (sref_int[r])
			);
		end
	endgenerate

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			rank_clk_oe_o     <= {RANKS{1'b1}};
			rank_cs_oe_o      <= {RANKS{1'b1}};
			cke_o             <= {RANKS{1'b0}};
			close_pages_o     <= {RANKS{1'b0}};
			pages_closed_o    <= {RANKS{1'b0}};
			in_self_refresh_o <= {RANKS{1'b0}};
		end
		else
		begin
			rank_clk_oe_o     <= populated & clk_en;
			rank_cs_oe_o      <= populated;
			cke_o             <= populated & cke_int;
			close_pages_o     <= close_int & populated;
			pages_closed_o    <= pclosed_int;
			in_self_refresh_o <= sref_int;
		end
	end

	// Pad order within a sub-channel, ascending: CA0 CA1 CS1 CS0 CA2..CA6
	// seen from one end; descending simply mirrors the nine pads.
	integer s;
	integer b;
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ca_cs_pad_o    <= {(SUBCH*9){1'b0}};
			ca_cs_pad_oe_o <= {(SUBCH*9){1'b0}};
			ca_cs_rx_o     <= {(SUBCH*9){1'b0}};
			rx_enable_o    <= {SUBCH{1'b0}};
		end
		else
		begin
			for (s = 0; s < SUBCH; s = s + 1)
			begin
				rx_enable_o[s] <= ~subch_unused_i[s];
				for (b = 0; b < 9; b = b + 1)
				begin
					if (descending_i[s])
					begin
						ca_cs_pad_o[s*9+b] <= ca_cs_logical_i[s*9+8-b];
						ca_cs_rx_o[s*9+b]  <= pad_in_s2[s*9+8-b] & ~subch_unused_i[s];
					end
					else
					begin
						ca_cs_pad_o[s*9+b] <= ca_cs_logical_i[s*9+b];
						ca_cs_rx_o[s*9+b]  <= pad_in_s2[s*9+b] & ~subch_unused_i[s];
					end
					// Sub-channels with no memory behind them float their pads.
					ca_cs_pad_oe_o[s*9+b] <= ~subch_unused_i[s];
				end
			end
		end
	end

endmodule

/* dram_pm_regs.vh */
/*
 * Constants for the DRAM power-management block: power-down modes, package
 * states, timing figures and reset values.
 * Assumes inclusion by bare name from the design files only.
 */
`ifndef DRAM_PM_REGS_VH
`define DRAM_PM_REGS_VH

// Power-down settings.
`define PD_MODE_NONE      2'h0
`define PD_MODE_PRECHARGE 2'h1
`define PD_MODE_ACTIVE    2'h2

// Package C-state encoding, higher is deeper.
`define PKG_C0            3'h0
`define PKG_C3            3'h3

// Power-down exit delay, in ns, and clock rate in MHz.
`define TXP_NS            20
`define CLK_MHZ           10

// Reset values.
`define IDLE_THRESH_RESET 16'h0040
`define POPULATED_RESET   1'h1

// Rank state machine codes.
`define RS_ACTIVE         3'h0
`define RS_CLOSE          3'h1
`define RS_PDOWN          3'h2
`define RS_EXIT           3'h3
`define RS_SREF           3'h4

`endif

/* rank_pm.v */
/*
 * Per-rank power-down controller: idle counter, entry into the selected
 * power-down mode, exit timing, refresh wake-up and self-refresh.
 * Assumes all inputs are synchronous to clk_i; the counter ticks once per
 * DRAM clock cycle as flagged by dram_clock_cycle_tick_i.
 */
`timescale 1ns/1ps
`include "dram_pm_regs.vh"

module rank_pm #(
	parameter IDLE_W = 16,
	parameter TXP_W  = 8
)(
	input  wire              clk_i,
	input  wire              rst_i,
	input  wire              dram_clock_cycle_tick_i,
	input  wire [1:0]        pd_mode_i,
	input  wire [IDLE_W-1:0] idle_thresh_i,
	input  wire [TXP_W-1:0]  txp_cycles_i,
	input  wire              busy_i,
	input  wire              new_txn_i,
	input  wire              banks_precharged_i,
	input  wire              refresh_req_i,
	input  wire              sref_req_i,
	input  wire              gfx_rank_i,
	output reg               cke_o,
	output reg               clk_en_o,
	output reg               close_pages_o,
	output reg               pages_closed_o,
	output reg               ready_o,
	output reg               in_sref_o
);

	reg [2:0]        state;
	reg [IDLE_W-1:0] idle_cnt;
	reg [TXP_W-1:0]  exit_cnt;
	reg              exit_from_ppd;

	wire idle_done = (idle_cnt >= idle_thresh_i);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state          <= `RS_ACTIVE;
			idle_cnt       <= {IDLE_W{1'b0}};
			exit_cnt       <= {TXP_W{1'b0}};
			exit_from_ppd  <= 1'b0;
			cke_o          <= 1'b1;
			clk_en_o       <= 1'b1;
			close_pages_o  <= 1'b0;
			pages_closed_o <= 1'b0;
			ready_o        <= 1'b1;
			in_sref_o      <= 1'b0;
		end
		else
		begin
			pages_closed_o <= 1'b0;
			// Idle counting only advances while the rank has nothing queued.
			if (busy_i || new_txn_i)
				idle_cnt <= {IDLE_W{1'b0}};
			else if (dram_clock_cycle_tick_i && !idle_done)
				idle_cnt <= idle_cnt + {{(IDLE_W-1){1'b0}}, 1'b1};
			case (state)
			`RS_ACTIVE:
			begin
				ready_o <= 1'b1;
				if (sref_req_i && !gfx_rank_i && !busy_i)
				begin
					state     <= `RS_SREF;
					cke_o     <= 1'b0;
					clk_en_o  <= 1'b0;
					in_sref_o <= 1'b1;
					ready_o   <= 1'b0;
				end
				else if (pd_mode_i != `PD_MODE_NONE && idle_done && !new_txn_i
					&& !busy_i && !refresh_req_i)
				begin
					if (pd_mode_i == `PD_MODE_PRECHARGE && !banks_precharged_i)
					begin
						state         <= `RS_CLOSE;
						close_pages_o <= 1'b1;
					end
					else
					begin
						state         <= `RS_PDOWN;
						exit_from_ppd <= (pd_mode_i == `PD_MODE_PRECHARGE);
						cke_o         <= 1'b0;
						clk_en_o      <= 1'b0;
						ready_o       <= 1'b0;
					end
				end
			end
			`RS_CLOSE:
			begin
				if (new_txn_i || refresh_req_i || busy_i)
				begin
					state         <= `RS_ACTIVE;
					close_pages_o <= 1'b0;
				end
				else if (banks_precharged_i)
				begin
					state         <= `RS_PDOWN;
					close_pages_o <= 1'b0;
					exit_from_ppd <= 1'b1;
					cke_o         <= 1'b0;
					clk_en_o      <= 1'b0;
					ready_o       <= 1'b0;
				end
			end
			`RS_PDOWN:
			begin
				// Refresh wakes the rank; the idle count is kept, so it drops back as soon as the refresh request ends.
				if (new_txn_i || refresh_req_i || sref_req_i || busy_i)
				begin
					state    <= `RS_EXIT;
					cke_o    <= 1'b1;
					clk_en_o <= 1'b1;
					exit_cnt <= txp_cycles_i;
				end
			end
			`RS_EXIT:
			begin
				if (exit_cnt > {{(TXP_W-1){1'b0}}, 1'b1})
					exit_cnt <= exit_cnt - {{(TXP_W-1){1'b0}}, 1'b1};
				else
				begin
					state          <= `RS_ACTIVE;
					ready_o        <= 1'b1;
					pages_closed_o <= exit_from_ppd;
				end
			end
			`RS_SREF:
			begin
				cke_o <= 1'b0;
				if (!sref_req_i || new_txn_i)
				begin
					state     <= `RS_EXIT;
					in_sref_o <= 1'b0;
					cke_o     <= 1'b1;
					clk_en_o  <= 1'b1;
					exit_cnt  <= txp_cycles_i;
					exit_from_ppd <= 1'b1;
				end
			end
			default:
				state <= `RS_ACTIVE;
			endcase
		end
	end

endmodule

/* dram_pm_chk.sv */
/* Port assertions for the DRAM power-management block.
   Assumes a bind to the top module with two ranks and two sub-channels. */
`timescale 1ns/1ps
module dram_pm_chk #(
	parameter RANKS  = 2,
	parameter SUBCH  = 2,
	parameter IDLE_W = 16
)(
	input wire              clk_i,
	input wire              rst_i,
	input wire [1:0]        power_down_config_i,
	input wire [RANKS-1:0]  rank_empty_i,
	input wire [RANKS-1:0]  rank_new_txn_i,
	input wire [RANKS-1:0]  banks_precharged_i,
	input wire [SUBCH-1:0]  descending_i,
	input wire [SUBCH-1:0]  subch_unused_i,
	input wire [SUBCH*9-1:0] ca_cs_logical_i,
	input wire [SUBCH*9-1:0] ca_cs_pad_o,
	input wire [SUBCH*9-1:0] ca_cs_pad_oe_o,
	input wire [SUBCH-1:0]  rx_enable_o,
	input wire [RANKS-1:0]  rank_clk_oe_o,
	input wire [RANKS-1:0]  rank_cs_oe_o,
	input wire [RANKS-1:0]  cke_o,
	input wire [RANKS-1:0]  in_self_refresh_o,
	input wire              refresh_go_o,
	input wire              state_return_i,
	input wire              skip_training_o,
	input wire              idle_thresh_we_i,
	input wire              regs_locked_i,
	input wire [IDLE_W-1:0] idle_thresh_o
);
	default clocking cb @(posedge clk_i);
	endclocking
	default disable iff (rst_i);
	// Pad b of a descending sub-channel carries logical bit 8-b.
	function automatic [8:0] mirror9(input [8:0] v);
		integer j;
		begin
			for (j = 0; j < 9; j = j + 1)
				mirror9[j] = v[8 - j];
		end
	endfunction
	a_empty_pins_off: assert property (rank_empty_i[1] |-> ##[1:3]
		(!rank_cs_oe_o[1] && !rank_clk_oe_o[1])) else $error("empty rank driven");
	a_desc_order: assert property (!$past(rst_i) && descending_i[0]
		&& !subch_unused_i[0] |=> ca_cs_pad_o[8:0] == mirror9($past(ca_cs_logical_i[8:0])))
		else $error("descending order wrong");
	a_unused_off: assert property (subch_unused_i[1] |=>
		(ca_cs_pad_oe_o[17:9] == 9'h000 && !rx_enable_o[1])) else $error("unused pins on");
	a_pd_clk_gated: assert property (!$past(rst_i) && !cke_o[0] && !in_self_refresh_o[0]
		|-> !rank_clk_oe_o[0]) else $error("clock runs in power-down");
	a_ppd_closed: assert property ($fell(cke_o[0]) && power_down_config_i == 2'h1
		&& !in_self_refresh_o[0]
		|-> $past(banks_precharged_i[0], 2)) else $error("power-down with open banks");
	a_refresh_wake: assert property (refresh_go_o |->
		(cke_o | ~rank_cs_oe_o) == {RANKS{1'b1}}) else $error("refresh with rank down");
	a_lock_refused: assert property (regs_locked_i && idle_thresh_we_i
		|=> $stable(idle_thresh_o)) else $error("locked threshold changed");
	a_skip_train: assert property (state_return_i |-> ##[1:3] skip_training_o)
		else $error("training not skipped");
	a_txn_wake: assert property (rank_new_txn_i[0] && !cke_o[0]
		&& !in_self_refresh_o[0] && rank_cs_oe_o[0] |-> ##[1:4] cke_o[0])
		else $error("rank not woken");
	c_pd: cover property ($fell(cke_o[0]));
	c_refresh: cover property (refresh_go_o);
	c_sref: cover property ($rose(in_self_refresh_o[0]));
endmodule
bind dram_power_management dram_pm_chk #(.RANKS(RANKS), .SUBCH(SUBCH), .IDLE_W(IDLE_W))
	chk_u (.*);

/* dram_dev_model.sv */
/* Far-side DRAM model: returns the CA/CS wire levels to the pad receivers
   and tracks whether one rank's banks are all pre-charged.
   Assumes it is clocked by the system clock. */
`timescale 1ns/1ps
module dram_dev_model #(
	parameter W = 18
)(
	input  wire         clk_i,
	input  wire [W-1:0] pad_i,
	input  wire [W-1:0] pad_oe_i,
	input  wire         open_i,
	input  wire         close_i,
	output wire [W-1:0] pad_o,
	output reg          closed_o = 1'h1
);
	reg [W-1:0] last = {W{1'b0}};
	// A released wire has no pull, so it toggles rather than keeping a stale level.
	assign pad_o = (pad_i & pad_oe_i) | (~last & ~pad_oe_i);
	always @(posedge clk_i)
	begin
		last <= pad_o;
		if (open_i)
			closed_o <= 1'h0;
		else if (close_i)
			closed_o <= 1'h1;
	end
endmodule

/* dram_power_management_tb_top.sv */
/* Self-checking bench for the DRAM power-management block.
   Assumes the design's default sizes: two ranks, two sub-channels. */
`timescale 1ns/1ps
module dram_power_management_tb_top;
	reg         clk_i = 1'h0, rst_i = 1'h1, dram_clk_i = 1'h0, idle_thresh_we_i = 1'h0;
	reg         regs_locked_i = 1'h0, refresh_req_i = 1'h0, s3_entry_i = 1'h0;
	reg         pending_cycles_i = 1'h0, state_return_i = 1'h0;
	reg         skip_seen = 1'h0;
	reg  [1:0]  power_down_config_i = 2'h0, rank_empty_i = 2'h0, rank_busy_i = 2'h2;
	reg  [1:0]  rank_new_txn_i = 2'h0, gfx_rank_i = 2'h2, descending_i = 2'h0;
	reg  [1:0]  subch_unused_i = 2'h0;
	reg  [2:0]  pkg_cstate_i = 3'h0;
	reg  [15:0] idle_thresh_wdata_i = 16'h0000;
	reg  [17:0] ca_cs_logical_i = 18'h00000, e_pad, e_oe;
	wire [17:0] ca_cs_pad_in_i, ca_cs_pad_o, ca_cs_pad_oe_o, ca_cs_rx_o;
	wire [1:0]  banks_precharged_i, rx_enable_o, rank_clk_oe_o, rank_cs_oe_o, cke_o;
	wire [1:0]  rank_ready_o, close_pages_o, pages_closed_o, in_self_refresh_o;
	wire [15:0] idle_thresh_o;
	wire        flush_req_o, refresh_go_o, interface_power_gating_o, skip_training_o, pre;
	integer     err_count = 0, tests_run = 0, cyc = 0, i, k, m, s, thr;
	integer     pc_count = 0, pc_base = 0;
	dram_power_management dut_u (.*);
	dram_dev_model #(.W(18)) dev_u (.clk_i(clk_i), .pad_i(ca_cs_pad_o),
		.pad_oe_i(ca_cs_pad_oe_o), .open_i(rank_new_txn_i[0]),
		.close_i(close_pages_o[0]), .pad_o(ca_cs_pad_in_i), .closed_o(pre));
	// Rank 1 always holds open pages, so only rank 0 is modelled in detail.
	assign banks_precharged_i = {1'h0, pre};
	initial forever #50 clk_i = ~clk_i;
	initial
	begin
		#137;
		forever #400 dram_clk_i = ~dram_clk_i;
	end
	task chk(input string name, input [31:0] e, input [31:0] g);
	begin
		tests_run = tests_run + 1;
		if (g !== e)
		begin
			err_count = err_count + 1;
			$display("Error %0s expected %h seen %h", name, e, g);
		end
	end
	endtask
	task cyc_n(input integer n);
		repeat (n) @(negedge clk_i);
	endtask
	task wr(input [15:0] v);
	begin
		idle_thresh_wdata_i = v;
		idle_thresh_we_i = 1'h1;
		cyc_n(1);
		idle_thresh_we_i = 1'h0;
		cyc_n(1);
	end
	endtask
	task pulse_txn;
	begin
		rank_new_txn_i[0] = 1'h1;
		cyc_n(1);
		rank_new_txn_i[0] = 1'h0;
	end
	endtask
	task end_of_test;
	begin
		$display("Checks %0d errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	end
	endtask
	always @(posedge clk_i)
	begin
		cyc = cyc + 1;
		if (pages_closed_o[0])
			pc_count <= pc_count + 1;
		if (skip_training_o)
			skip_seen <= 1'h1;
		if (cyc == 20000)
		begin
			err_count = err_count + 1;
			end_of_test;
		end
	end
	initial
	begin
		thr = $urandom(32'h5d89);
		thr = 3 + $urandom % 3;
		cyc_n(4);
		rst_i = 1'h0;
		cyc_n(1);
		chk("cs_oe", 3, rank_cs_oe_o);
		chk("clk_oe", 3, rank_clk_oe_o);
		regs_locked_i = 1'h1;
		wr(thr[15:0]);
		chk("thresh_locked", 16'h0040, idle_thresh_o);
		regs_locked_i = 1'h0;
		wr(thr[15:0]);
		chk("thresh", thr, idle_thresh_o);
		for (i = 0; i < 8; i = i + 1)
		begin
			descending_i = i[1:0];
			subch_unused_i = i[2:1];
			ca_cs_logical_i = 18'($urandom);
			cyc_n(5);
			for (k = 0; k < 18; k = k + 1)
			begin
				s = k / 9;
				e_pad[k] = ca_cs_logical_i[descending_i[s] ? s * 9 + 8 - k % 9 : k];
				e_oe[k] = !subch_unused_i[s];
			end
			chk("pad", e_pad & e_oe, ca_cs_pad_o & e_oe);
			chk("pad_oe", e_oe, ca_cs_pad_oe_o);
			chk("rx_en", {2'h3 ^ subch_unused_i}, rx_enable_o);
			// The receive path undoes the pad mirror, so it returns logical order.
			chk("rx", ca_cs_logical_i & e_oe, ca_cs_rx_o);
		end
		subch_unused_i = 2'h0;
		for (m = 0; m < 3; m = m + 1)
		begin
			power_down_config_i = m[1:0];
			pulse_txn;
			rank_busy_i[0] = 1'h1;
			cyc_n(3);
			rank_busy_i[0] = 1'h0;
			cyc_n(8 * thr - 16);
			chk("cke_early", 1, cke_o[0]);
			cyc_n(44);
			chk("cke_idle", m == 0, cke_o[0]);
			chk("clk_gate", m == 0, rank_clk_oe_o[0]);
			chk("banks_closed", m == 1, pre);
			pc_base = pc_count;
			pulse_txn;
			cyc_n(6);
			chk("cke_wake", 1, cke_o[0]);
			chk("ready", 1, rank_ready_o[0]);
			chk("pages_closed", m == 1, pc_count - pc_base);
		end
		cyc_n(8 * thr + 28);
		chk("cke_pd", 0, cke_o[0]);
		refresh_req_i = 1'h1;
		for (i = 0; i < 40 && refresh_go_o !== 1'h1; i = i + 1)
			cyc_n(1);
		chk("refresh_go", 1, refresh_go_o);
		chk("cke_all", 3, cke_o);
		refresh_req_i = 1'h0;
		cyc_n(8 * thr + 28);
		chk("cke_back", 0, cke_o[0]);
		rank_busy_i[1] = 1'h0;
		pkg_cstate_i = 3'h3;
		pending_cycles_i = 1'h1;
		cyc_n(6);
		chk("flush", 1, flush_req_o);
		chk("sref_wait", 0, in_self_refresh_o);
		pending_cycles_i = 1'h0;
		cyc_n(10);
		chk("sref", 1, in_self_refresh_o);
		chk("cke_sref", 0, cke_o[0]);
		chk("gating", 1, interface_power_gating_o);
		pkg_cstate_i = 3'h0;
		state_return_i = 1'h1;
		cyc_n(1);
		state_return_i = 1'h0;
		cyc_n(10);
		chk("skip", 1, skip_seen);
		chk("sref_exit", 0, in_self_refresh_o);
		s3_entry_i = 1'h1;
		cyc_n(10);
		chk("sref_s3", 1, in_self_refresh_o);
		chk("cke_s3", 0, cke_o[0]);
		s3_entry_i = 1'h0;
		cyc_n(10);
		chk("sref_s3_exit", 0, in_self_refresh_o);
		rank_empty_i = 2'h2;
		cyc_n(1);
		rank_empty_i = 2'h0;
		cyc_n(4);
		chk("cs_oe_empty", 1, rank_cs_oe_o);
		chk("clk_oe_empty", 0, rank_clk_oe_o[1]);
		end_of_test;
	end
endmodule
